// [cfg_header_pkg.sv]
// Offsets, field layouts and reset values of the configuration header registers
package cfg_header_pkg;

  // Byte offsets of the registers; dword-aligned except the header type/self-test offset 0Eh
  localparam logic [7:0] OFS_HEADER_DWORD = 8'h0C;
  localparam logic [7:0] OFS_HEADER_TYPE_SELFTEST = 8'h0E;
  localparam logic [7:0] OFS_HOST_CTRL_WINDOW_BASE = 8'h10;
  localparam logic [7:0] OFS_VENDOR_EXT_WINDOW_BASE = 8'h14;
  localparam logic [7:0] OFS_CARD_INFO_WINDOW_BASE = 8'h18;

  // Fixed field values
  localparam logic [7:0] SELFTEST_VALUE = 8'h00;
  localparam logic [7:0] HEADER_TYPE_VALUE = 8'h80;
  localparam logic [15:0] HEADER_TYPE_SELFTEST_RESET = 16'h0080;

  // Writable pointer masks
  localparam logic [31:0] HOST_WINDOW_PTR_MASK = 32'hFFFF_F800;
  localparam logic [31:0] VENDOR_WINDOW_PTR_MASK = 32'hFFFF_C000;
  localparam logic [31:0] CARD_INFO_PTR_MASK = 32'hFFFF_F800;
  localparam logic [31:0] WINDOW_BASE_RESET = 32'h0000_0000;

  // Low attribute fields of every window base: size, prefetch, locate type, space flag
  localparam logic [6:0] WINDOW_SIZE_VALUE = 7'h00;
  localparam logic PREFETCH_VALUE = 1'b0;
  localparam logic [1:0] LOCATE_TYPE_VALUE = 2'h0;
  localparam logic SPACE_FLAG_VALUE = 1'b0;

  // Strap of the card mode input; tied high inside this function
  localparam logic CARD_MODE_STRAP_TIE = 1'b1;

  // Configuration access request
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [3:0] byte_en;
    logic [31:0] wdata;
  } cfg_req_type;

endpackage

// [cfg_header_bars.sv]
// Configuration header type and base address registers of the host controller function
//
// Functional notes
// (R1) Upper byte of header/self-test register reads zero: no self-test.
// (R2) Lower byte of header/self-test register reads 80h.
// (R3) Host window base bits 31..11 writable, reset to zero.
// (R4) All-ones write to host window base reads back FFFF_F800.
// (R5) Host window base bits 10..4 read zero (2 KB).
// (R6) Host window base bit 3 reads zero: not prefetchable.
// (R7) Host window base bits 2..1 read 00b: 32-bit, anywhere.
// (R8) Host window base bit 0 reads zero: memory space.
// (R9) Vendor window base bits 31..14 writable, reset to zero.
// (R10) All-ones write to vendor window base reads back FFFF_C000.
// (R11) Vendor window base bits 13..0 read zero.
// (R12) Card info pointer read-only zero when card mode strap high at reset.
// (R13) Card mode strap tied high internally; card info base reads zero.
// (R14) Card info base bits 10..4 read zero (2 KB).
// (R15) Software uses only byte accesses to the card information space.
// (R16) Card info base bits 3..0 read zero.
// (R17) Writes to read-only bits are ignored.
`timescale 1ns/1ns
module cfg_header_bars (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // Configuration access
  input wire cfg_header_pkg::cfg_req_type i_cfg_req,
  output logic [31:0] o_cfg_rdata,
  output logic o_cfg_rvalid,
  output logic o_cfg_hit,
  // Decoded window bases for the memory decoders
  output logic [31:0] o_host_window_base,
  output logic [31:0] o_vendor_window_base
);
  import cfg_header_pkg::*;

  logic [31:0] host_window_pointer;
  logic [31:0] vendor_window_pointer;
  logic [31:0] card_info_pointer;
  logic card_mode_strap;
  logic strap_taken;
  logic [31:0] wmask;
  logic [31:0] next_rdata;
  logic hit;

  // Byte enables spread to a bit mask; unselected lanes keep their value
  always_comb begin
    wmask = {{8{i_cfg_req.byte_en[3]}}, {8{i_cfg_req.byte_en[2]}},
             {8{i_cfg_req.byte_en[1]}}, {8{i_cfg_req.byte_en[0]}}};
  end

  // Strap is caught by a clocked process after reset release, never in reset itself
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      card_mode_strap <= 1'b0;
      strap_taken <= 1'b0;
    end else if (!strap_taken) begin
      // (R13) strap tied high
      card_mode_strap <= CARD_MODE_STRAP_TIE;
      strap_taken <= 1'b1;
    end
  end

  // (R3) host pointer writable bits
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      host_window_pointer <= WINDOW_BASE_RESET;
    end else if (i_cfg_req.wr && i_cfg_req.addr == OFS_HOST_CTRL_WINDOW_BASE) begin
      // (R17) fixed bits masked off
      host_window_pointer <= ((i_cfg_req.wdata & wmask) | (host_window_pointer & ~wmask))
                             & HOST_WINDOW_PTR_MASK;
    end
  end

  // (R9) vendor pointer writable bits
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      vendor_window_pointer <= WINDOW_BASE_RESET;
    end else if (i_cfg_req.wr && i_cfg_req.addr == OFS_VENDOR_EXT_WINDOW_BASE) begin
      // (R17) fixed bits masked off
      vendor_window_pointer <= ((i_cfg_req.wdata & wmask) | (vendor_window_pointer & ~wmask))
                               & VENDOR_WINDOW_PTR_MASK;
    end
  end

  // (R12) pointer frozen at zero while strap high; strap low before capture also holds zero
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      card_info_pointer <= WINDOW_BASE_RESET;
    end else if (card_mode_strap || !strap_taken) begin
      card_info_pointer <= WINDOW_BASE_RESET;
    end else if (i_cfg_req.wr && i_cfg_req.addr == OFS_CARD_INFO_WINDOW_BASE) begin
      card_info_pointer <= ((i_cfg_req.wdata & wmask) | (card_info_pointer & ~wmask))
                           & CARD_INFO_PTR_MASK;
    end
  end

  // Read multiplexer; unmapped offsets are not claimed and read zero
  always_comb begin
    next_rdata = 32'h0000_0000;
    hit = 1'b1;
    case (i_cfg_req.addr)
      OFS_HEADER_DWORD, OFS_HEADER_TYPE_SELFTEST: begin
        // (R1) (R2) self-test zero, header 80h in upper half of dword
        next_rdata = {SELFTEST_VALUE, HEADER_TYPE_VALUE, 16'h0000};
      end
      OFS_HOST_CTRL_WINDOW_BASE: begin
        // (R4) (R5) (R6) (R7) (R8) fixed low attribute bits
        next_rdata = {host_window_pointer[31:11], WINDOW_SIZE_VALUE, PREFETCH_VALUE,
                      LOCATE_TYPE_VALUE, SPACE_FLAG_VALUE};
      end
      OFS_VENDOR_EXT_WINDOW_BASE: begin
        // (R10) (R11) low fourteen bits zero
        next_rdata = {vendor_window_pointer[31:14], 3'h0, WINDOW_SIZE_VALUE, PREFETCH_VALUE,
                      LOCATE_TYPE_VALUE, SPACE_FLAG_VALUE};
      end
      OFS_CARD_INFO_WINDOW_BASE: begin
        // (R14) (R16) fixed low attribute bits
        next_rdata = {card_info_pointer[31:11], WINDOW_SIZE_VALUE, PREFETCH_VALUE,
                      LOCATE_TYPE_VALUE, SPACE_FLAG_VALUE};
      end
      default: begin
        hit = 1'b0;
      end
    endcase
  end

  // Read data registered one cycle after the request
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_cfg_rdata <= 32'h0000_0000;
      o_cfg_rvalid <= 1'b0;
    end else begin
      o_cfg_rvalid <= i_cfg_req.rd;
      if (i_cfg_req.rd) begin
        o_cfg_rdata <= next_rdata;
      end
    end
  end

  assign o_cfg_hit = hit & (i_cfg_req.rd | i_cfg_req.wr);
  assign o_host_window_base = host_window_pointer;
  assign o_vendor_window_base = vendor_window_pointer;

endmodule

// [cfg_header_bars_assertions.sv]
// Port checks for the configuration header registers
`timescale 1ns/1ns
module cfg_header_bars_assertions (
  // Watched ports
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire cfg_header_pkg::cfg_req_type i_cfg_req,
  input wire logic [31:0] o_cfg_rdata,
  input wire logic o_cfg_rvalid,
  input wire logic o_cfg_hit,
  input wire logic [31:0] o_host_window_base,
  input wire logic [31:0] o_vendor_window_base
);
  import cfg_header_pkg::*;
  cfg_req_type q;
  assign q = i_cfg_req;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  sequence s_rd(a);
    q.rd && q.addr == a;
  endsequence
  // Full-lane writes only, so the masked image is exact
  sequence s_wr(a);
    q.wr && q.addr == a && q.byte_en == 4'hF;
  endsequence
  a_header_fixed: assert property (q.rd && (q.addr == OFS_HEADER_DWORD || q.addr == OFS_HEADER_TYPE_SELFTEST)
    |=> o_cfg_rdata == 32'h0080_0000) else $error("bad header read");
  a_host_sizing: assert property (s_wr(OFS_HOST_CTRL_WINDOW_BASE)
    |=> o_host_window_base == ($past(q.wdata) & HOST_WINDOW_PTR_MASK)) else $error("bad host base");
  a_host_low_zero: assert property (o_host_window_base[10:0] == 11'h000)
    else $error("host low bits set");
  a_vendor_sizing: assert property (s_wr(OFS_VENDOR_EXT_WINDOW_BASE)
    |=> o_vendor_window_base == ($past(q.wdata) & VENDOR_WINDOW_PTR_MASK)) else $error("bad vendor");
  a_vendor_low_zero: assert property (o_vendor_window_base[13:0] == 14'h0000)
    else $error("vendor low bits set");
  a_card_info_zero: assert property (s_rd(OFS_CARD_INFO_WINDOW_BASE) |=> o_cfg_rdata == 32'h0)
    else $error("card info not zero");
  a_host_hold: assert property (!(q.wr && q.addr == OFS_HOST_CTRL_WINDOW_BASE)
    |=> $stable(o_host_window_base)) else $error("host base moved");
  a_host_readback: assert property (s_rd(OFS_HOST_CTRL_WINDOW_BASE)
    |=> o_cfg_rvalid && o_cfg_rdata == $past(o_host_window_base)) else $error("bad host read");
endmodule
bind cfg_header_bars cfg_header_bars_assertions i_cfg_header_bars_assertions (
  .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_cfg_req(i_cfg_req), .o_cfg_rdata(o_cfg_rdata),
  .o_cfg_rvalid(o_cfg_rvalid), .o_cfg_hit(o_cfg_hit), .o_host_window_base(o_host_window_base),
  .o_vendor_window_base(o_vendor_window_base));

// [cfg_host_model.sv]
// Host configuration software model issuing header accesses
`timescale 1ns/1ns
module cfg_host_model (
  // Clock and device answer
  input wire logic i_ref_clk,
  input wire logic [31:0] i_cfg_rdata,
  input wire logic i_cfg_hit,
  // Request to the device
  output cfg_header_pkg::cfg_req_type o_cfg_req
);
  import cfg_header_pkg::*;
  initial o_cfg_req = '0;
  // no wide card-space access
  // Only base registers are sized; the card data space itself is never touched
  task automatic xfer(input logic r, w, input logic [7:0] a, input logic [3:0] be,
      input logic [31:0] wd, output logic [31:0] rdat, output logic hit);
    @(posedge i_ref_clk);
    o_cfg_req <= '{r, w, a, be, wd};
    @(posedge i_ref_clk);
    hit = i_cfg_hit;
    // Released lines show the inverse so stale values never pass for data
    o_cfg_req <= '{1'b0, 1'b0, ~a, ~be, ~wd};
    @(posedge i_ref_clk);
    rdat = i_cfg_rdata;
  endtask
endmodule

// [cfg_header_bars_tb_top.sv]
// Self-checking bench for the configuration header registers
`timescale 1ns/1ns
module cfg_header_bars_tb_top;
  import cfg_header_pkg::*;
  typedef struct packed {logic [7:0] a; logic [3:0] be; logic [31:0] wd, ex; logic h;} row_type;
  logic i_ref_clk = 1'b0;
  logic i_rst_n = 1'b0;
  cfg_req_type req;
  logic [31:0] rdata, hbase, vbase, got;
  logic rvalid, hit, ghit;
  int n_fail = 0;
  int compares = 0;
  row_type rows [7] = '{'{8'h10, 4'hF, 32'hFFFF_FFFF, 32'hFFFF_F800, 1'b1},
    '{8'h14, 4'hF, 32'hFFFF_FFFF, 32'hFFFF_C000, 1'b1},
    '{8'h18, 4'hF, 32'hFFFF_FFFF, 32'h0000_0000, 1'b1},
    '{8'h0E, 4'hF, 32'hFFFF_FFFF, 32'h0080_0000, 1'b1},
    '{8'h10, 4'hF, 32'h1234_5678, 32'h1234_5000, 1'b1},
    '{8'h10, 4'h8, 32'hAB00_0000, 32'hAB34_5000, 1'b1},
    '{8'h20, 4'hF, 32'hFFFF_FFFF, 32'h0000_0000, 1'b0}};
  cfg_header_bars i_cfg_header_bars (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
    .i_cfg_req(req), .o_cfg_rdata(rdata), .o_cfg_rvalid(rvalid), .o_cfg_hit(hit),
    .o_host_window_base(hbase), .o_vendor_window_base(vbase));
  cfg_host_model i_cfg_host_model (.i_ref_clk(i_ref_clk), .i_cfg_rdata(rdata),
    .i_cfg_hit(hit), .o_cfg_req(req));
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    compares++;
    if (seen !== want) begin
      n_fail++;
      $display("[FAIL] %0t: saw %h, want %h", $time, seen, want);
    end
  endtask
  task automatic finish_test();
    if (n_fail == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic go(input logic r, w, input logic [7:0] a, input logic [3:0] be,
      input logic [31:0] wd);
    i_cfg_host_model.xfer(r, w, a, be, wd, got, ghit);
  endtask
  initial forever #5 i_ref_clk = ~i_ref_clk;
  initial begin
    #20000;
    n_fail++;
    finish_test();
  end
  initial begin
    repeat (8) @(posedge i_ref_clk);
    i_rst_n <= 1'b1;
    foreach (rows[k]) begin
      go(1'b0, 1'b1, rows[k].a, rows[k].be, rows[k].wd);
      go(1'b1, 1'b0, rows[k].a, 4'hF, 32'h0000_0000);
      chk(got, rows[k].ex);
      chk(32'(ghit), 32'(rows[k].h));
    end
    // Read and write together: the old value answers, the new one is kept
    go(1'b1, 1'b1, OFS_HOST_CTRL_WINDOW_BASE, 4'hF, 32'hFFFF_FFFF);
    chk(got, 32'hAB34_5000);
    chk(hbase, 32'hFFFF_F800);
    chk(vbase, 32'hFFFF_C000);
    repeat (2) @(posedge i_ref_clk);
    i_rst_n <= 1'b0;
    repeat (8) @(posedge i_ref_clk);
    i_rst_n <= 1'b1;
    go(1'b1, 1'b0, OFS_VENDOR_EXT_WINDOW_BASE, 4'hF, 32'h0000_0000);
    chk(got, 32'h0000_0000);
    chk(hbase, 32'h0000_0000);
    finish_test();
  end
endmodule
